// ### src/iso_rx_trailer_and_rx_router.sv
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns

// ********************************************************************
// receive buffer
// ********************************************************************
module rx_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // honest full and empty from the occupancy count
    assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid_o = (count_reg != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr_reg];

    // storage has no reset, only pointers and count do
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    // pointers wrap because depth is a power of two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            case ({push, pop})
                2'b10:   count_reg <= count_reg + 1'b1;
                2'b01:   count_reg <= count_reg - 1'b1;
                default: count_reg <= count_reg;
            endcase
        end
    end

    a_fifo_no_overflow: assert property (@(posedge clk_i) disable iff (rst_i)
        count_reg <= (AW+1)'(DEPTH))
        else $error("fifo count above depth");

endmodule : rx_fifo

// ********************************************************************
// trailer register and receive router
// ********************************************************************
module iso_rx_trailer_and_rx_router (
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    // wishbone slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [11:0]                wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // isochronous receive quadlet stream
    input  wire logic                       rx_valid_i,
    output logic                            rx_ready_o,
    input  wire logic [31:0]                rx_data_i,
    input  wire logic                       rx_trailer_i,
    output logic                            iso_valid_o,
    input  wire logic                       iso_ready_i,
    output logic      [31:0]                iso_data_o,
    output logic                            iso_trailer_o,
    // packet classification from the receive decoder
    input  wire logic                       pkt_valid_i,
    input  wire logic                       pkt_async_i,
    input  wire logic                       pkt_selfid_i,
    input  wire logic                       pkt_resp_match_i,
    input  wire logic                       pkt_request_i,
    input  wire logic                       pkt_broadcast_i,
    input  wire logic                       pkt_reg_space_i,
    input  wire logic                       pkt_above_thresh_i,
    input  wire logic                       pkt_wr_lock_i,
    input  wire logic                       pkt_good_i,
    output logic                            route_valid_o,
    output rx_router_pkg::dest_t            route_dest_o,
    output logic                            ack_valid_o,
    output logic      [3:0]                 ack_code_o,
    // video support
    input  wire logic                       dv_mode_i,
    input  wire logic                       video_frame_pulse_i,
    output logic                            empty_ins_reset_o,
    output logic                            continuity_check_en_o
);
    logic [31:0]          iso_rx_trailer_reg;
    logic [31:0]          rx_router_control_reg;
    logic [31:0]          control_next;
    logic [31:0]          rd_data;
    logic                 bus_req;
    logic                 wr_control_hit;
    logic [31:0]          sel_mask;
    logic [32:0]          fifo_out;
    logic                 trailer_pop;
    logic                 fp_sync1_reg;
    logic                 fp_sync2_reg;
    logic                 fp_last_reg;
    logic                 fp_rise;
    logic [1:0]           route_mode;
    rx_router_pkg::dest_t dest_next;
    logic [3:0]           ack_next;

    // ****************************************************************
    // wishbone slave
    // ****************************************************************

    // one wait state: ack rises the cycle after the strobe, then drops
    assign bus_req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_control_hit = bus_req && wb_we_i
                            && (wb_adr_i == rx_router_pkg::RX_ROUTER_CONTROL_ADDR);
    assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // unmapped addresses still ack so the master never hangs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // read mux; write-only and unused bits read zero
    always_comb begin
        rd_data = 32'h00000000;
        case (wb_adr_i)
            rx_router_pkg::ISO_RX_TRAILER_ADDR:
                rd_data = iso_rx_trailer_reg;
            rx_router_pkg::RX_ROUTER_CONTROL_ADDR:
                rd_data = rx_router_control_reg
                          & rx_router_pkg::CONTROL_RD_MASK;
            default:
                rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    // ****************************************************************
    // router control register
    // ****************************************************************

    // byte lanes honoured; only implemented bits take a write
    assign control_next = (rx_router_control_reg & ~(sel_mask
                          & rx_router_pkg::CONTROL_WR_MASK))
                          | (wb_dat_i & sel_mask
                          & rx_router_pkg::CONTROL_WR_MASK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_router_control_reg <= rx_router_pkg::CONTROL_RESET;
        end else if (wr_control_hit) begin
            rx_router_control_reg <= control_next;
        end
    end

    a_ctrl_reset_val: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i)
            |-> !rx_router_control_reg[rx_router_pkg::FRAME_RST_BIT]
            && rx_router_control_reg[rx_router_pkg::ACK_PEND_BIT]
            && rx_router_control_reg[rx_router_pkg::SELFID_ROUTE_BIT])
        else $error("router control reset value wrong");

    a_ctrl_unused_zero: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (rx_router_control_reg & ~rx_router_pkg::CONTROL_WR_MASK) == '0)
        else $error("unused control bit became set");

    // ****************************************************************
    // receive buffer and trailer capture
    // ****************************************************************

    // back-pressure from the iso consumer fills the buffer
    rx_fifo #(
        .WIDTH (rx_router_pkg::RX_FIFO_WIDTH),
        .DEPTH (rx_router_pkg::RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (rx_valid_i),
        .in_ready_o  (rx_ready_o),
        .in_data_i   ({rx_trailer_i, rx_data_i}),
        .out_valid_o (iso_valid_o),
        .out_ready_i (iso_ready_i),
        .out_data_o  (fifo_out)
    );

    assign iso_data_o    = fifo_out[31:0];
    assign iso_trailer_o = fifo_out[32];
    assign trailer_pop   = iso_valid_o && iso_ready_i && fifo_out[32];

    // only speed, pad count and ack code are kept; bus writes ignored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            iso_rx_trailer_reg <= rx_router_pkg::TRAILER_RESET;
        end else if (trailer_pop) begin
            iso_rx_trailer_reg <= fifo_out[31:0]
                                  & rx_router_pkg::TRAILER_FIELD_MASK;
        end
    end

    a_trailer_load: assert property (@(posedge clk_i)
        disable iff (rst_i)
        trailer_pop |=> iso_rx_trailer_reg
            == ($past(fifo_out[31:0]) & rx_router_pkg::TRAILER_FIELD_MASK))
        else $error("trailer not loaded from transferred quadlet");

    a_trailer_hold: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !trailer_pop |=> $stable(iso_rx_trailer_reg))
        else $error("trailer changed without a trailer transfer");

    a_trailer_reset: assert property (@(posedge clk_i)
        !rst_i && $past(rst_i) |-> iso_rx_trailer_reg == 32'h00000000)
        else $error("trailer not cleared by reset");

    a_trailer_fields: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (iso_rx_trailer_reg & ~rx_router_pkg::TRAILER_FIELD_MASK) == '0)
        else $error("trailer holds bits outside its fields");

    // ****************************************************************
    // video frame pulse
    // ****************************************************************

    // pin is asynchronous; edge detector reads only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fp_sync1_reg <= 1'b0;
            fp_sync2_reg <= 1'b0;
            fp_last_reg  <= 1'b0;
        end else begin
            fp_sync1_reg <= video_frame_pulse_i;
            fp_sync2_reg <= fp_sync1_reg;
            fp_last_reg  <= fp_sync2_reg;
        end
    end

    assign fp_rise = fp_sync2_reg && !fp_last_reg;

    // one-cycle reset pulse to the empty-packet inserter
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            empty_ins_reset_o <= 1'b0;
        end else begin
            empty_ins_reset_o <= fp_rise && dv_mode_i
                && rx_router_control_reg[rx_router_pkg::FRAME_RST_BIT];
        end
    end

    a_frame_reset: assert property (@(posedge clk_i)
        disable iff (rst_i)
        empty_ins_reset_o == ($past(fp_rise) && $past(dv_mode_i)
            && $past(rx_router_control_reg[rx_router_pkg::FRAME_RST_BIT])))
        else $error("empty packet reset pulse wrong");

    // continuity checking on unless software disabled it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            continuity_check_en_o <= 1'b1;
        end else begin
            continuity_check_en_o <=
                !rx_router_control_reg[rx_router_pkg::CONT_DIS_BIT];
        end
    end

    a_cont_check: assert property (@(posedge clk_i)
        disable iff (rst_i)
        $past(rx_router_control_reg[rx_router_pkg::CONT_DIS_BIT])
            |-> !continuity_check_en_o)
        else $error("continuity check not disabled");

    // ****************************************************************
    // packet routing and acknowledge
    // ****************************************************************

    assign route_mode = {rx_router_control_reg[rx_router_pkg::MODE_HI_BIT],
                         rx_router_control_reg[rx_router_pkg::MODE_LO_BIT]};

    // self-id first, then matched responses, then async modes
    always_comb begin
        dest_next = rx_router_pkg::DEST_NONE;
        if (pkt_selfid_i) begin
            dest_next = rx_router_control_reg[rx_router_pkg::SELFID_ROUTE_BIT]
                        ? rx_router_pkg::DEST_BULK_ASYNC
                        : rx_router_pkg::DEST_BROADCAST;
        end else if (pkt_async_i && pkt_resp_match_i) begin
            dest_next = rx_router_control_reg[rx_router_pkg::RESP_ROUTE_BIT]
                        ? rx_router_pkg::DEST_ASYNC_CTRL
                        : rx_router_pkg::DEST_BULK_ASYNC;
        end else if (pkt_async_i) begin
            case (route_mode)
                rx_router_pkg::MODE_SPLIT:
                    dest_next = pkt_broadcast_i
                                ? rx_router_pkg::DEST_BROADCAST
                                : rx_router_pkg::DEST_ASYNC_CTRL;
                rx_router_pkg::MODE_REGSPACE: begin
                    if (pkt_request_i && pkt_reg_space_i) begin
                        dest_next = pkt_broadcast_i
                                    ? rx_router_pkg::DEST_BROADCAST
                                    : rx_router_pkg::DEST_ASYNC_CTRL;
                    end else begin
                        dest_next = rx_router_pkg::DEST_BULK_ASYNC;
                    end
                end
                rx_router_pkg::MODE_ALL_BULK:
                    dest_next = rx_router_pkg::DEST_BULK_DATA;
                rx_router_pkg::MODE_THRESHOLD: begin
                    if (pkt_request_i && pkt_above_thresh_i) begin
                        dest_next = pkt_broadcast_i
                                    ? rx_router_pkg::DEST_BROADCAST
                                    : rx_router_pkg::DEST_ASYNC_CTRL;
                    end else begin
                        dest_next = rx_router_pkg::DEST_BULK_DATA;
                    end
                end
                default:
                    dest_next = rx_router_pkg::DEST_NONE;
            endcase
        end
    end

    // a bad packet is data error whatever the pending setting
    always_comb begin
        ack_next = rx_router_pkg::ACK_COMPLETE;
        if (!pkt_good_i) begin
            ack_next = rx_router_pkg::ACK_DATA_ERROR;
        end else if (pkt_request_i && pkt_wr_lock_i
                     && rx_router_control_reg[rx_router_pkg::ACK_PEND_BIT]) begin
            ack_next = rx_router_pkg::ACK_PENDING;
        end
    end

    // decisions registered so the valids are clean one-cycle pulses; dest and ack code hold until the next packet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_valid_o <= 1'b0;
            route_dest_o  <= rx_router_pkg::DEST_NONE;
            ack_valid_o   <= 1'b0;
            ack_code_o    <= 4'h0;
        end else begin
            route_valid_o <= pkt_valid_i;
            ack_valid_o   <= pkt_valid_i && pkt_async_i;
            if (pkt_valid_i) begin
                route_dest_o <= dest_next;
                ack_code_o   <= ack_next;
            end
        end
    end

    a_ack_pending: assert property (@(posedge clk_i)
        disable iff (rst_i)
        pkt_valid_i && pkt_async_i && pkt_good_i && pkt_request_i
            && pkt_wr_lock_i |=> ack_valid_o && ack_code_o
            == ($past(rx_router_control_reg[rx_router_pkg::ACK_PEND_BIT])
                ? rx_router_pkg::ACK_PENDING : rx_router_pkg::ACK_COMPLETE))
        else $error("write or lock ack code wrong");

    a_ack_error: assert property (@(posedge clk_i)
        disable iff (rst_i)
        pkt_valid_i && pkt_async_i && !pkt_good_i
            |=> ack_code_o == rx_router_pkg::ACK_DATA_ERROR)
        else $error("bad packet not acked with data error");

    a_selfid_route: assert property (@(posedge clk_i)
        disable iff (rst_i)
        pkt_valid_i && pkt_selfid_i
            && !rx_router_control_reg[rx_router_pkg::SELFID_ROUTE_BIT]
            |=> route_dest_o == rx_router_pkg::DEST_BROADCAST)
        else $error("self-id not routed to broadcast fifo");

    a_resp_route: assert property (@(posedge clk_i)
        disable iff (rst_i)
        pkt_valid_i && !pkt_selfid_i && pkt_async_i && pkt_resp_match_i
            |=> route_dest_o == ($past(rx_router_control_reg
                [rx_router_pkg::RESP_ROUTE_BIT])
                ? rx_router_pkg::DEST_ASYNC_CTRL
                : rx_router_pkg::DEST_BULK_ASYNC))
        else $error("matched response routed wrong");

    a_all_bulk_mode: assert property (@(posedge clk_i)
        disable iff (rst_i)
        pkt_valid_i && pkt_async_i && !pkt_selfid_i && !pkt_resp_match_i
            && route_mode == rx_router_pkg::MODE_ALL_BULK
            |=> route_dest_o == rx_router_pkg::DEST_BULK_DATA)
        else $error("mode 10 did not route to bulk data fifo");

endmodule : iso_rx_trailer_and_rx_router

// ### src/rx_router_pkg.sv
package rx_router_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam logic [11:0] ISO_RX_TRAILER_ADDR    = 12'h144;
    localparam logic [11:0] RX_ROUTER_CONTROL_ADDR = 12'h148;

    // ****************************************************************
    // iso_rx_trailer fields
    // ****************************************************************
    localparam int          RX_SPEED_LSB       = 14;
    localparam int          PAD_COUNT_LSB      = 22;
    localparam int          SENT_ACK_LSB       = 28;
    localparam logic [31:0] TRAILER_FIELD_MASK = 32'hf0c0c000;
    localparam logic [31:0] TRAILER_RESET      = 32'h00000000;

    // ****************************************************************
    // rx_router_control fields
    // ****************************************************************
    localparam int          FRAME_RST_BIT    = 15;
    localparam int          ACK_PEND_BIT     = 17;
    localparam int          CONT_DIS_BIT     = 19;
    localparam int          RESP_ROUTE_BIT   = 20;
    localparam int          SELFID_ROUTE_BIT = 21;
    localparam int          MODE_LO_BIT      = 22;
    localparam int          MODE_HI_BIT      = 23;
    localparam logic [31:0] CONTROL_WR_MASK  = 32'h00fa8000;
    localparam logic [31:0] CONTROL_RD_MASK  = 32'h00f28000;
    localparam logic [31:0] CONTROL_RESET    = 32'h00220000;

    // ****************************************************************
    // speed and acknowledge codes
    // ****************************************************************
    localparam logic [1:0] SPEED_100 = 2'h0;
    localparam logic [1:0] SPEED_200 = 2'h1;
    localparam logic [3:0] ACK_COMPLETE   = 4'h1;
    localparam logic [3:0] ACK_PENDING    = 4'h2;
    localparam logic [3:0] ACK_BUSY_X     = 4'h4;
    localparam logic [3:0] ACK_BUSY_A     = 4'h5;
    localparam logic [3:0] ACK_BUSY_B     = 4'h6;
    localparam logic [3:0] ACK_DATA_ERROR = 4'hd;
    localparam logic [3:0] ACK_TYPE_ERROR = 4'he;

    // ****************************************************************
    // routing modes and destinations
    // ****************************************************************
    localparam logic [1:0] MODE_SPLIT     = 2'h0;
    localparam logic [1:0] MODE_REGSPACE  = 2'h1;
    localparam logic [1:0] MODE_ALL_BULK  = 2'h2;
    localparam logic [1:0] MODE_THRESHOLD = 2'h3;

    typedef enum logic [2:0] {
        DEST_NONE,
        DEST_BULK_ASYNC,
        DEST_ASYNC_CTRL,
        DEST_BROADCAST,
        DEST_BULK_DATA
    } dest_t;

    // ****************************************************************
    // receive buffer
    // ****************************************************************
    localparam int RX_FIFO_WIDTH = 33;
    localparam int RX_FIFO_DEPTH = 16;

endpackage : rx_router_pkg

// ### testbench/iso_rx_trailer_and_rx_router_tb.sv
`timescale 1ns/1ns
module iso_rx_trailer_and_rx_router_tb;
    logic        clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_we_i = 0, stall = 1;
    logic        rx_valid_i = 0, rx_trailer_i = 0, pkt_valid_i = 0;
    logic        dv_mode_i = 0, video_frame_pulse_i = 0, iso_ready_i;
    logic [11:0] wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0, rx_data_i = 0, wb_dat_o, iso_data_o, q, c, tw;
    logic [8:0]  f = 0;
    logic [3:0]  wb_sel_i = 4'hf, ack_code_o;
    logic        wb_stb_i, wb_ack_o, rx_ready_o, iso_valid_o, iso_trailer_o;
    logic        route_valid_o, ack_valid_o;
    logic        empty_ins_reset_o, continuity_check_en_o;
    logic        pkt_async_i, pkt_selfid_i, pkt_resp_match_i, pkt_request_i;
    logic        pkt_broadcast_i, pkt_reg_space_i, pkt_above_thresh_i;
    logic        pkt_wr_lock_i, pkt_good_i;
    rx_router_pkg::dest_t route_dest_o;
    int          err_count = 0, n_compared = 0, cycles = 0, i, d, e, k;
    int          seed = 32'hf593;
    logic [31:0] exp_q[$];

    // packet flags travel as one vector so a single random draw sets all
    assign wb_stb_i = wb_cyc_i;
    assign {pkt_async_i, pkt_selfid_i, pkt_resp_match_i, pkt_request_i,
            pkt_broadcast_i, pkt_reg_space_i, pkt_above_thresh_i,
            pkt_wr_lock_i, pkt_good_i} = f;

    iso_rx_trailer_and_rx_router dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
        .rx_valid_i, .rx_ready_o, .rx_data_i, .rx_trailer_i, .iso_valid_o,
        .iso_ready_i, .iso_data_o, .iso_trailer_o, .pkt_valid_i,
        .pkt_async_i, .pkt_selfid_i, .pkt_resp_match_i, .pkt_request_i,
        .pkt_broadcast_i, .pkt_reg_space_i, .pkt_above_thresh_i,
        .pkt_wr_lock_i, .pkt_good_i, .route_valid_o, .route_dest_o,
        .ack_valid_o, .ack_code_o, .dv_mode_i, .video_frame_pulse_i,
        .empty_ins_reset_o, .continuity_check_en_o);
    iso_sink sink (.clk_i(clk_i), .stall_i(stall), .ready_o(iso_ready_i));

    initial forever #2 clk_i = ~clk_i;

    // hang guard, well above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_compared++;
        if (s !== x) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    // one classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [11:0] a,
                      input logic [31:0] v, output logic [31:0] r);
        @(posedge clk_i);
        {wb_cyc_i, wb_we_i, wb_adr_i, wb_dat_i} <= {1'b1, w, a, v};
        // no limit of its own; the hang guard ends a lost answer
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        r = wb_dat_o;
        wb_cyc_i <= 0;
    endtask : wb

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        wb(0, 12'h144, 0, q);
        chk(q, 0);
        wb(0, 12'h148, 0, q);
        chk(q, 32'h00220000);
        wb(1, 12'h148, '1, q);
        wb(0, 12'h148, 0, q);
        chk(q, 32'h00f28000);
        chk(continuity_check_en_o, 0);
        // byte lane 1 only: clears bit 15, upper lanes keep their bits
        wb_sel_i <= 4'h2;
        wb(1, 12'h148, 0, q);
        wb_sel_i <= 4'hf;
        wb(0, 12'h148, 0, q);
        chk(q, 32'h00f20000);
        wb(0, 12'h1fc, 0, q);
        chk(q, 0);
        // fill to refusal while the sink stalls; trailer sits mid-stream
        tw = $random(seed);
        for (i = 0; i < 16; i++) begin
            @(posedge clk_i);
            d = (i == 7) ? tw : i * 32'h11111111;
            {rx_valid_i, rx_data_i, rx_trailer_i} <= {1'b1, d, i == 7};
            exp_q.push_back(d);
        end
        @(posedge clk_i);
        rx_valid_i <= 0;
        @(posedge clk_i);
        chk(rx_ready_o, 0);
        stall <= 0;
        repeat (24) begin
            @(posedge clk_i);
            if (iso_valid_o === 1 && iso_ready_i === 1)
                chk(iso_data_o, exp_q.pop_front());
        end
        chk(exp_q.size(), 0);
        wb(1, 12'h144, '1, q);
        wb(0, 12'h144, 0, q);
        chk(q, tw & 32'hf0c0c000);
        // random packets against a reference router, control reshuffled
        for (i = 0; i < 96; i++) begin
            if (i % 8 == 0) c = $random(seed) & 32'h00fa8000;
            if (i % 8 == 0) wb(1, 12'h148, c, q);
            k = $random(seed);
            @(posedge clk_i);
            {pkt_valid_i, f} <= {1'b1, k[8:0]};
            @(posedge clk_i);
            pkt_valid_i <= 0;
            @(posedge clk_i);
            if (k[7]) d = c[21] ? 1 : 3;
            else if (!k[8]) d = 0;
            else if (k[6]) d = c[20] ? 2 : 1;
            else if (c[23:22] == 2) d = 4;
            else if (c[22] ? k[5] && (c[23] ? k[2] : k[3]) : 1)
                d = k[4] ? 3 : 2;
            else d = c[23] ? 4 : 1;
            e = !k[0] ? 13 : (k[5] && k[1] && c[17]) ? 2 : 1;
            chk(route_valid_o, 1);
            chk(route_dest_o, d);
            chk(ack_valid_o, k[8]);
            if (k[8]) chk(ack_code_o, e);
            chk(continuity_check_en_o, !c[19]);
        end
        // frame pulse over every pairing of reset bit and video mode
        for (i = 3; i >= 0; i--) begin
            wb(1, 12'h148, {16'h0000, i[0], 15'h0000}, q);
            {video_frame_pulse_i, dv_mode_i} <= {1'b1, i[1]};
            d = 0;
            repeat (8) begin
                @(posedge clk_i);
                if (empty_ins_reset_o !== 1'b0) d++;
            end
            chk(d, i == 3);
            video_frame_pulse_i <= 0;
            repeat (4) @(posedge clk_i);
        end
        complete_run();
    end
endmodule : iso_rx_trailer_and_rx_router_tb

// ### testbench/iso_sink.sv
`timescale 1ns/1ns
// downstream consumer of the iso stream, can hold off on request
module iso_sink (
    input  wire logic clk_i,
    input  wire logic stall_i,
    output logic      ready_o
);
    // ready only moves after an edge, as a registered consumer would
    always_ff @(posedge clk_i) begin
        ready_o <= !stall_i;
    end
endmodule : iso_sink
